// ---- src/acc_ops_pkg.sv ----
// Constants and types shared by the accumulator bit operation unit.
// Assumes a single 20 MHz clock domain and a sequencer on the same clock.
package acc_ops_pkg;
   localparam int ACC_WIDTH   = 32;
   localparam int INDEX_WIDTH = 5;
   localparam int COUNT_WIDTH = 6;
   localparam int BCD_DIGITS  = 8;
   localparam int CONV_STEPS  = 32;
   localparam logic [COUNT_WIDTH-1:0] COUNT_MIN = 6'h01;
   localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 6'h20;
   localparam logic [ACC_WIDTH-1:0]   ACC_RESET = 32'h00000000;
   localparam logic [INDEX_WIDTH-1:0] INDEX_TOP = 5'h1F;

   typedef enum logic [2:0] {
      shift_right_op       = 3'h0,
      rotate_left_op       = 3'h1,
      rotate_right_op      = 3'h2,
      bit_index_encode_op  = 3'h3,
      one_hot_decode_op    = 3'h4,
      decimal_to_binary_op = 3'h5,
      binary_to_decimal_op = 3'h6,
      load_op              = 3'h7
   } acc_op_e;

   typedef enum logic [1:0] {
      st_idle = 2'h0,
      st_conv = 2'h1,
      st_done = 2'h2
   } unit_state_e;
endpackage

// ---- src/bcd_converter.sv ----
// Iterative converter between packed BCD and unsigned binary, one bit per cycle.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
module bcd_converter
   import acc_ops_pkg::*;
(
   input  wire logic                 clk,       // System clock.
   input  wire logic                 reset,     // Synchronous reset, active high.
   input  wire logic                 start,     // Begin a conversion.
   input  wire logic                 to_binary, // High: BCD to binary; low: binary to BCD.
   input  wire logic [ACC_WIDTH-1:0] operand,   // Value to convert.
   output logic                      busy,      // Conversion in progress.
   output logic                      done,      // One-cycle pulse with result valid.
   output logic      [ACC_WIDTH-1:0] result     // Converted value.
);
   logic [ACC_WIDTH-1:0] bin_reg;
   logic [ACC_WIDTH-1:0] bcd_reg;
   logic [5:0]           steps;
   logic                 mode;
   logic [ACC_WIDTH-1:0] next_bin_reg;
   logic [ACC_WIDTH-1:0] next_bcd_reg;
   logic [5:0]           next_steps;
   logic                 next_mode;
   logic                 next_busy;
   logic                 next_done;
   logic [ACC_WIDTH-1:0] adj;

   // Double-dabble in either direction: add 3 before shifting left, subtract 3 after shifting right.
   always_comb begin
      adj          = bcd_reg;
      next_bin_reg = bin_reg;
      next_bcd_reg = bcd_reg;
      next_steps   = steps;
      next_mode    = mode;
      next_busy    = busy;
      next_done    = 1'b0;
      if (start && !busy) begin
         next_busy    = 1'b1;
         next_mode    = to_binary;
         next_steps   = 6'(CONV_STEPS);
         next_bin_reg = to_binary ? ACC_RESET : operand;
         next_bcd_reg = to_binary ? operand : ACC_RESET;
      end else if (busy) begin
         if (mode) begin
            next_bin_reg = {bcd_reg[0], bin_reg[ACC_WIDTH-1:1]};
            adj = {1'b0, bcd_reg[ACC_WIDTH-1:1]};
            for (int d = 0; d < BCD_DIGITS; d++) begin
               if (adj[d*4 +: 4] >= 4'h8) begin
                  adj[d*4 +: 4] = adj[d*4 +: 4] - 4'h3;
               end
            end
            next_bcd_reg = adj;
         end else begin
            for (int d = 0; d < BCD_DIGITS; d++) begin
               if (adj[d*4 +: 4] >= 4'h5) begin
                  adj[d*4 +: 4] = adj[d*4 +: 4] + 4'h3;
               end
            end
            next_bcd_reg = {adj[ACC_WIDTH-2:0], bin_reg[ACC_WIDTH-1]};
            next_bin_reg = {bin_reg[ACC_WIDTH-2:0], 1'b0};
         end
         next_steps = steps - 6'h01;
         if (steps == 6'h01) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bin_reg <= ACC_RESET;
         bcd_reg <= ACC_RESET;
         steps   <= 6'h00;
         mode    <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         bin_reg <= next_bin_reg;
         bcd_reg <= next_bcd_reg;
         steps   <= next_steps;
         mode    <= next_mode;
         busy    <= next_busy;
         done    <= next_done;
      end
   end

   // Values above the 8-digit range wrap; binary inputs above 99999999 lose upper digits.
   assign result = mode ? bin_reg : bcd_reg;
endmodule

// ---- src/accumulator_bit_ops_unit.sv ----
// Accumulator datapath for shift, rotate, encode, decode and BCD conversion.
// Assumes a program sequencer on clk that issues one operation and waits for ready.
`timescale 1ns/1ps
module accumulator_bit_ops_unit
   import acc_ops_pkg::*;
(
   input  wire logic                   clk,                // 20 MHz system clock.
   input  wire logic                   reset,              // Synchronous reset, active high.
   input  wire logic                   op_valid,           // Operation issued this cycle.
   input  wire logic [2:0]             op_code,            // Operation selector (acc_op_e).
   input  wire logic [COUNT_WIDTH-1:0] op_count,           // Shift or rotate count, 1 to 32.
   input  wire logic [ACC_WIDTH-1:0]   load_value,         // Value for load_op.
   output logic                        ready,              // High when an operation may be issued.
   output logic                        op_done,            // One-cycle pulse when the result is written.
   output logic      [ACC_WIDTH-1:0]   accumulator,        // Accumulator contents.
   output logic                        operand_range_flag  // Encode saw more than one set bit.
);
   unit_state_e          state;
   unit_state_e          next_state;
   logic [ACC_WIDTH-1:0] next_accumulator;
   logic                 next_flag;
   logic                 next_ready;
   logic                 next_done;
   logic                 conv_start;
   logic                 conv_busy;
   logic                 conv_done;
   logic [ACC_WIDTH-1:0] conv_result;
   logic [ACC_WIDTH-1:0] alu_result;
   logic                 alu_multi;
   logic                 is_conv;

   // Index of the lowest set bit; zero when no bit is set.
   function automatic logic [INDEX_WIDTH-1:0] lowest_set(input logic [ACC_WIDTH-1:0] v);
      logic [INDEX_WIDTH-1:0] idx;
      idx = '0;
      for (int i = ACC_WIDTH - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = INDEX_WIDTH'(i);
         end
      end
      return idx;
   endfunction

   // Counts outside 1..32 are clamped to 1 or 32; a stray value above 32 rotates by 32 and yields an unrotated result.
   function automatic logic [COUNT_WIDTH-1:0] clamp_count(input logic [COUNT_WIDTH-1:0] c);
      if (c < COUNT_MIN) begin
         return COUNT_MIN;
      end else if (c > COUNT_MAX) begin
         return COUNT_MAX;
      end
      return c;
   endfunction

   always_comb begin
      logic [COUNT_WIDTH-1:0] cnt;
      logic [2*ACC_WIDTH-1:0] dbl;
      logic [INDEX_WIDTH-1:0] idx;
      cnt        = clamp_count(op_count);
      dbl        = '0;
      idx        = '0;
      alu_result = accumulator;
      alu_multi  = 1'b0;
      case (op_code)
         shift_right_op: begin
            alu_result = (cnt == COUNT_MAX) ? ACC_RESET : (accumulator >> cnt);
         end
         rotate_left_op: begin
            dbl        = {accumulator, accumulator} << cnt;
            alu_result = dbl[2*ACC_WIDTH-1:ACC_WIDTH];
         end
         rotate_right_op: begin
            dbl        = {accumulator, accumulator} >> cnt;
            alu_result = dbl[ACC_WIDTH-1:0];
         end
         bit_index_encode_op: begin
            alu_result = {{(ACC_WIDTH-INDEX_WIDTH){1'b0}}, lowest_set(accumulator)};
            alu_multi  = (accumulator & (accumulator - 32'h00000001)) != ACC_RESET;
         end
         one_hot_decode_op: begin
            // Dividing by 32 until below 32 leaves the top nonzero 5-bit group.
            idx = accumulator[INDEX_WIDTH-1:0];
            for (int g = 1; g * INDEX_WIDTH < ACC_WIDTH; g++) begin
               if ((accumulator >> (g * INDEX_WIDTH)) != ACC_RESET) begin
                  idx = 5'((accumulator >> (g * INDEX_WIDTH)) & 32'h0000001F);
               end
            end
            alu_result = 32'h00000001 << idx;
         end
         load_op: begin
            alu_result = load_value;
         end
         default: begin
            alu_result = accumulator;
         end
      endcase
   end

   assign is_conv    = (op_code == decimal_to_binary_op) || (op_code == binary_to_decimal_op);
   assign conv_start = (state == st_idle) && op_valid && is_conv;

   bcd_converter u_conv (
      .clk       (clk),
      .reset     (reset),
      .start     (conv_start),
      .to_binary (op_code == decimal_to_binary_op),
      .operand   (accumulator),
      .busy      (conv_busy),
      .done      (conv_done),
      .result    (conv_result)
   );

   always_comb begin
      next_state       = state;
      next_accumulator = accumulator;
      next_flag        = operand_range_flag;
      next_ready       = ready;
      next_done        = 1'b0;
      case (state)
         st_idle: begin
            if (op_valid && is_conv) begin
               next_state = st_conv;
               next_ready = 1'b0;
            end else if (op_valid) begin
               next_accumulator = alu_result;
               next_done        = 1'b1;
               if (op_code == bit_index_encode_op) begin
                  next_flag = alu_multi;
               end
            end
         end
         st_conv: begin
            if (conv_done) begin
               next_accumulator = conv_result;
               next_done        = 1'b1;
               next_ready       = 1'b1;
               next_state       = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
            next_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state              <= st_idle;
         accumulator        <= ACC_RESET;
         operand_range_flag <= 1'b0;
         ready              <= 1'b1;
         op_done            <= 1'b0;
      end else begin
         state              <= next_state;
         accumulator        <= next_accumulator;
         operand_range_flag <= next_flag;
         ready              <= next_ready;
         op_done            <= next_done;
      end
   end

   sequence s_rotate_left_op_issue;
      ready && op_valid && op_code == rotate_left_op && op_count == 6'h01;
   endsequence

   sequence s_conv_issue;
      ready && op_valid && op_code == decimal_to_binary_op;
   endsequence

   chk_shift_zero_fill: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == shift_right_op && op_count == 6'h01
      |=> accumulator == {1'b0, $past(accumulator[ACC_WIDTH-1:1])})
      else $error("shift right did not zero fill");

   chk_rotate_left_op_wrap: assert property (@(posedge clk) disable iff (reset)
      s_rotate_left_op_issue |=> accumulator == {$past(accumulator[ACC_WIDTH-2:0]), $past(accumulator[ACC_WIDTH-1])})
      else $error("rotate left lost the top bit");

   chk_rotate_right_op_wrap: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == rotate_right_op && op_count == 6'h20
      |=> $stable(accumulator))
      else $error("rotate right by 32 changed the accumulator");

   chk_encode_top: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == bit_index_encode_op && accumulator == 32'h80000000
      |=> accumulator == 32'h0000001F && !operand_range_flag)
      else $error("encode of top bit is wrong");

   chk_encode_multi: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == bit_index_encode_op && accumulator == 32'h00000006
      |=> accumulator == 32'h00000001 && operand_range_flag)
      else $error("multiple bits not flagged");

   chk_flag_hold: assert property (@(posedge clk) disable iff (reset)
      !(ready && op_valid && op_code == bit_index_encode_op) |=> $stable(operand_range_flag))
      else $error("range flag changed without encode");

   chk_decode_bit: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == one_hot_decode_op && accumulator == 32'h0000000F
      |=> accumulator == 32'h00008000)
      else $error("decode of 15 did not set bit 15");

   chk_decode_divide: assert property (@(posedge clk) disable iff (reset)
      ready && op_valid && op_code == one_hot_decode_op && accumulator == 32'h00000040
      |=> accumulator == 32'h00000004)
      else $error("decode did not divide by 32");

   chk_conv_atomic: assert property (@(posedge clk) disable iff (reset)
      s_conv_issue |=> !ready ##[1:40] op_done && ready)
      else $error("conversion did not finish in time");

   chk_bcd_value: assert property (@(posedge clk) disable iff (reset)
      (s_conv_issue and (accumulator == 32'h00000099)) |=> ##[1:40] op_done && accumulator == 32'h00000063)
      else $error("BCD to binary gave a wrong value");
endmodule

// ---- bench/op_sequencer.sv ----
// Behavioural program sequencer that issues accumulator operations.
// Assumes the same clk as the unit and that each task is entered at a rising edge.
`timescale 1ns/1ps
module op_sequencer
   import acc_ops_pkg::*;
(
   input  wire logic                   clk,        // System clock.
   input  wire logic                   ready,      // Unit can take an operation.
   output logic                        op_valid,   // Operation request.
   output logic      [2:0]             op_code,    // Operation selector.
   output logic      [COUNT_WIDTH-1:0] op_count,   // Shift or rotate count.
   output logic      [ACC_WIDTH-1:0]   load_value  // Value for load_op.
);
   initial begin
      op_valid   = 1'b0;
      op_code    = 3'h0;
      op_count   = 6'h01;
      load_value = 32'h00000000;
   end

   // The request stays up after it is taken, so a following call can issue back to back.
   task automatic issue(input logic [2:0] op, input logic [COUNT_WIDTH-1:0] cnt,
                        input logic [ACC_WIDTH-1:0] val, output bit ok);
      int n;
      n = 0;
      op_valid   <= 1'b1;
      op_code    <= op;
      op_count   <= cnt;
      load_value <= val;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 200);
      ok = (ready === 1'b1);
   endtask

   // A load held for one cycle while the unit is busy must be ignored.
   task automatic refused(input logic [ACC_WIDTH-1:0] val);
      op_valid   <= 1'b1;
      op_code    <= load_op;
      load_value <= val;
      @(posedge clk);
      op_valid   <= 1'b0;
   endtask

   task automatic idle();
      op_valid <= 1'b0;
   endtask
endmodule

// ---- bench/tb_accumulator_bit_ops_unit.sv ----
// Self-checking bench for the accumulator bit operation unit.
// Assumes the sequencer model drives all operation inputs; a watcher checks each result.
`timescale 1ns/1ps
module tb_accumulator_bit_ops_unit;
   import acc_ops_pkg::*;
   logic                   clk;
   logic                   reset;
   logic                   op_valid;
   logic [2:0]             op_code;
   logic [COUNT_WIDTH-1:0] op_count;
   logic [ACC_WIDTH-1:0]   load_value;
   logic                   ready;
   logic                   op_done;
   logic [ACC_WIDTH-1:0]   accumulator;
   logic                   operand_range_flag;
   logic [32:0]            q[$];
   logic [31:0]            acc_m;
   logic                   flag_m;
   logic [2:0]             op;
   logic [5:0]             cnt;
   logic [5:0]             cnts[3];
   int                     n_fail;
   int                     n_compared;

   accumulator_bit_ops_unit uut (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
      .op_count(op_count), .load_value(load_value), .ready(ready), .op_done(op_done),
      .accumulator(accumulator), .operand_range_flag(operand_range_flag));
   op_sequencer seq (.clk(clk), .ready(ready), .op_valid(op_valid), .op_code(op_code),
      .op_count(op_count), .load_value(load_value));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [32:0] model(logic [2:0] o, logic [5:0] c, logic [31:0] a, logic f,
                                         logic [31:0] lv);
      int          n;
      logic [31:0] r;
      logic [31:0] v;
      n = (c < 1) ? 1 : (c > 32) ? 32 : int'(c);
      r = a;
      v = a;
      case (o)
         shift_right_op:  r = (n == 32) ? 32'h0 : a >> n;
         rotate_left_op:  r = (n == 32) ? a : (a << n) | (a >> (32 - n));
         rotate_right_op: r = (n == 32) ? a : (a >> n) | (a << (32 - n));
         bit_index_encode_op: begin
            r = 32'h0;
            for (int i = 31; i >= 0; i--) if (a[i]) r = 32'(i);
            f = ((a & (a - 32'h1)) != 32'h0);
         end
         one_hot_decode_op: begin
            while (v > 31) v = v >> 5;
            r = 32'h1 << v;
         end
         decimal_to_binary_op: begin
            r = 32'h0;
            for (int i = 7; i >= 0; i--) r = r * 10 + a[4*i+:4];
         end
         binary_to_decimal_op: for (int i = 0; i < 8; i++) begin
            r[4*i+:4] = 4'(v % 10);
            v = v / 10;
         end
         default: r = lv;
      endcase
      return {f, r};
   endfunction

   function automatic logic [31:0] rand_bcd();
      logic [31:0] r;
      for (int i = 0; i < 8; i++) r[4*i+:4] = 4'($urandom_range(0, 9));
      return r;
   endfunction

   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Notes the expected result, then issues; conversions also get a refused load and a latency check.
   task automatic run(input logic [2:0] o, input logic [5:0] c, input logic [31:0] val);
      logic [32:0] e;
      bit          ok;
      int          n;
      e = model(o, c, acc_m, flag_m, val);
      {flag_m, acc_m} = e;
      q.push_back(e);
      seq.issue(o, c, val, ok);
      if (!ok) begin
         n_fail++;
         stop_test();
      end
      if (o == decimal_to_binary_op || o == binary_to_decimal_op) begin
         seq.refused(~val);
         n = 0;
         while (op_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
         end
         if (n >= 100) begin
            n_fail++;
            stop_test();
         end
         // The loop starts one edge after the issuing edge, so that edge is added back.
         check("conversion latency", 33'(n + 1), 33'd34);
      end
   endtask

   always @(posedge clk) begin
      if (reset === 1'b0 && op_done === 1'b1) begin
         if (q.size() == 0) check("unexpected result", 33'h1, 33'h0);
         else begin
            check("accumulator", {1'b0, accumulator}, {1'b0, q[0][31:0]});
            check("range flag", {32'h0, operand_range_flag}, {32'h0, q[0][32]});
            void'(q.pop_front());
         end
      end
   end

   initial begin
      n_fail = 0;
      n_compared = 0;
      acc_m = ACC_RESET;
      flag_m = 1'b0;
      cnts = '{6'h01, 6'h20, 6'h0A};
      void'($urandom(67644));
      reset = 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      check("reset accumulator", {1'b0, accumulator}, 33'h0);
      check("reset status", {30'h0, ready, op_done, operand_range_flag}, 33'h4);
      for (int k = 0; k < 3; k++) for (int c = 0; c < 3; c++) begin
         run(load_op, 6'h01, 32'hC000_0005);
         run(3'(k), cnts[c], 32'h0);
      end
      run(load_op, 6'h01, 32'h8000_0000);
      run(bit_index_encode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0118);
      run(bit_index_encode_op, 6'h01, 32'h0);
      run(shift_right_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0010);
      run(bit_index_encode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_000F);
      run(one_hot_decode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_03FF);
      run(one_hot_decode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0020);
      run(one_hot_decode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0040);
      run(one_hot_decode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0006);
      run(bit_index_encode_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h0000_0099);
      run(decimal_to_binary_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h1234_5678);
      run(decimal_to_binary_op, 6'h01, 32'h0);
      run(load_op, 6'h01, 32'h05F5_E0FF);
      run(binary_to_decimal_op, 6'h01, 32'h0);
      for (int i = 0; i < 60; i++) begin
         op = 3'($urandom_range(0, 6));
         cnt = 6'($urandom_range(1, 32));
         if (op == decimal_to_binary_op) run(load_op, cnt, rand_bcd());
         else if (op == binary_to_decimal_op) run(load_op, cnt, $urandom_range(0, 99999999));
         else if (i % 3 == 0) run(load_op, cnt, $urandom);
         run(op, cnt, $urandom);
      end
      seq.idle();
      repeat (4) @(posedge clk);
      check("pending results", 33'(q.size()), 33'h0);
      stop_test();
   end
endmodule
